//--- shared/voice_host_pkg.sv
package voice_host_pkg;

    // ========================================================
    // Command codes (upper bits of a command byte)
    // ========================================================
    localparam logic [4:0] CMD_START_C   = 5'h00; // 0000_0xxx
    localparam logic [4:0] CMD_STOP_C    = 5'h01; // 0000_1xxx
    localparam logic [4:0] CMD_LOOP_C    = 5'h02; // 0001_0xxx
    localparam logic [4:0] CMD_OPTION_C  = 5'h03; // 0001_1xxx
    localparam logic [4:0] CMD_SILENCE_C = 5'h04;
    localparam logic [4:0] CMD_PHRASE_C  = 5'h05;
    localparam logic [4:0] CMD_DIRECT_C  = 5'h06;
    localparam logic [4:0] CMD_VOLUME_C  = 5'h07;
    localparam logic [4:0] CMD_PAN_C     = 5'h08;

    // ========================================================
    // Option byte fields
    // ========================================================
    localparam int OPT_LPF_BIT      = 0;
    localparam int OPT_FOLLOWER_BIT = 1;
    localparam logic [7:0] OPTION_RESET = 8'h00;

    // Fields of the 7th direct-address byte
    localparam int DIR_RATE_LSB = 4;
    localparam int DIR_ALGO_LSB = 2;

    // ========================================================
    // Sampling groups and decoding schemes
    // ========================================================
    typedef enum logic [1:0] {
        GRP_ONE   = 2'h0,
        GRP_TWO   = 2'h1,
        GRP_THREE = 2'h2
    } group_e;

    typedef enum logic [1:0] {
        ALG_ADPCM    = 2'h0,
        ALG_ADPCM2   = 2'h1,
        ALG_PCM8     = 2'h2,
        ALG_NONLIN8  = 2'h3
    } algo_e;

    localparam logic [1:0] GROUP_RESET = 2'h0;
    localparam int CHANNELS  = 8;
    localparam int DAC_WIDTH = 14;

    // Bytes written by the host, tagged command or subcommand
    typedef struct packed {
        logic       isSub;
        logic [7:0] data;
    } host_byte_s;

    // Per-channel setup sent to the playback engine
    typedef struct packed {
        logic [3:0] rateCode;
        algo_e      algo;
    } chan_cfg_s;

endpackage

//--- rtl/voice_host_control.sv
`timescale 1ns/1ps
// Summary of operation
// (RULE_01) Phrase rate comes from its memory entry
// (RULE_02) Ten rates sorted into three groups
// (RULE_03) Host mixes same-group channels when filtering
// (RULE_04) Option command enables internal low-pass filter
// (RULE_05) First sounding channel fixes the group
// (RULE_06) Simultaneous starts: lowest channel sets group
// (RULE_07) Reset low means power-down and init
// (RULE_08) Crystal oscillator output pin low in power-down
// (RULE_09) External clock held low in power-down
// (RULE_10) Both audio outputs at ground in power-down
// (RULE_11) Reset held low during power-up
// (RULE_12) Four decoding schemes supported
// (RULE_13) ADPCM decodes one four-bit code per sample
// (RULE_14) Non-linear PCM expands to ten-bit centre
// (RULE_15) Fourteen-bit stereo held per sample period
// (RULE_16) Option selects direct or follower output
// (RULE_17) Interface pin selects parallel or serial
// (RULE_18) Parallel: nine commands, status register read
// (RULE_19) Serial: status on serial and nibble outputs
// (RULE_20) Serial mode reassigns the eight bus pins
// (RULE_21) Parallel writes framed, status driven on read
// (RULE_22) Command-select high means subcommand byte
// (RULE_23) Subcommands fill holding register, command moves
// (RULE_24) Serial bytes shifted in MSB first
// (RULE_25) Byte captured at write rising edge
module voice_host_control
    import voice_host_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic                  serialSelect,
    input  wire logic                  cmdSelect,
    input  wire logic                  chipSelect_n,
    input  wire logic                  write_n,
    input  wire logic                  read_n,
    input  wire logic [7:0]            hostDataIn,
    output logic      [7:0]            hostDataOut,
    output logic      [7:0]            hostDataOe,
    input  wire logic [CHANNELS-1:0]   chanBusy,
    input  wire logic [CHANNELS-1:0]   chanRateValid,
    input  wire logic [3:0]            chanRateCode [CHANNELS],
    input  wire logic                  crystalFitted,
    input  wire logic [DAC_WIDTH-1:0]  leftSample,
    input  wire logic [DAC_WIDTH-1:0]  rightSample,
    input  wire logic                  sampleTick,
    output logic                       oscEnable,
    output logic                       oscillatorPinOut,
    output logic      [DAC_WIDTH-1:0]  leftAudioOut,
    output logic      [DAC_WIDTH-1:0]  rightAudioOut,
    output logic                       lpfEnable,
    output logic                       followerOut,
    output group_e                     activeGroup,
    output logic      [CHANNELS-1:0]   startPulse,
    output logic      [CHANNELS-1:0]   stopPulse,
    output logic      [CHANNELS-1:0]   loopPulse,
    output logic                       cfgLoad,
    output logic      [2:0]            cfgChannel,
    output logic      [7:0]            cfgData,
    output logic      [4:0]            cfgCommand,
    output chan_cfg_s                  directCfg
);

    // ========================================================
    // Pin synchronisers
    // ========================================================
    logic [13:0] syncA;
    logic [13:0] syncB;
    wire  [13:0] rawPins = {serialSelect, cmdSelect, chipSelect_n,
                            write_n, read_n, hostDataIn, crystalFitted};

    // Two flip-flops per pin before use
    always_ff @(posedge clk_sys) begin
        syncA <= rawPins;
        syncB <= syncA;
    end

    wire       isSerial = syncB[13];       // RULE_17
    wire       cmdLvl   = syncB[12];
    wire       csN      = syncB[11];
    wire       wrN      = syncB[10];
    wire       rdN      = syncB[9];
    wire [7:0] dataPins = syncB[8:1];
    wire       xtal     = syncB[0];
    wire       serData  = dataPins[7];     // RULE_20
    wire       serClk   = dataPins[6];     // RULE_20
    wire       bankSel  = dataPins[4];     // RULE_20

    // ========================================================
    // Edge detection and byte capture
    // ========================================================
    logic       wrPrev;
    logic       sclkPrev;
    logic [7:0] shiftReg;
    logic [7:0] readShift;

    wire wrRise   = wrN && !wrPrev && !csN;           // RULE_25
    wire sclkRise = serClk && !sclkPrev;
    wire [7:0] next_shiftReg = {shiftReg[6:0], serData}; // RULE_24
    wire [7:0] wrByte = isSerial ? shiftReg : dataPins;
    host_byte_s inByte;
    assign inByte = '{isSub: cmdLvl, data: wrByte};   // RULE_22

    // Edge history and serial shift
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wrPrev   <= 1'b1;
            sclkPrev <= 1'b0;
            shiftReg <= 8'h00;
        end else begin
            wrPrev   <= wrN;
            sclkPrev <= serClk;
            if (isSerial && sclkRise && !csN && rdN) begin
                shiftReg <= next_shiftReg;  // RULE_24
            end
        end
    end

    // ========================================================
    // Command decode and holding register
    // ========================================================
    logic [7:0] tempHold [7];
    logic [2:0] holdCount;
    logic [7:0] optionReg;
    wire  [4:0] opCode  = inByte.data[7:3];
    wire  [2:0] opChan  = inByte.data[2:0];
    wire        doCmd   = wrRise && !inByte.isSub;  // RULE_23
    wire        doSub   = wrRise && inByte.isSub;   // RULE_23
    wire [CHANNELS-1:0] chanMask = tempHold[0];
    wire        knownOp = opCode <= CMD_PAN_C;      // RULE_18

    // Subcommand bytes pile into the holding register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            holdCount <= 3'h0;
            for (int i = 0; i < 7; i++) tempHold[i] <= 8'h00;
        end else if (doSub) begin
            tempHold[holdCount] <= inByte.data;   // RULE_23
            holdCount <= (holdCount == 3'h6) ? 3'h0 : holdCount + 3'h1;
        end else if (doCmd) begin
            holdCount <= 3'h0;
        end
    end

    // Command execution moves held data to function registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            optionReg  <= OPTION_RESET;           // RULE_07
            startPulse <= '0;
            stopPulse  <= '0;
            loopPulse  <= '0;
            cfgLoad    <= 1'b0;
            cfgChannel <= 3'h0;
            cfgData    <= 8'h00;
            cfgCommand <= 5'h00;
            directCfg  <= '0;
        end else begin
            startPulse <= (doCmd && opCode == CMD_START_C) ? chanMask : '0;
            stopPulse  <= (doCmd && opCode == CMD_STOP_C) ? chanMask : '0;
            loopPulse  <= (doCmd && opCode == CMD_LOOP_C) ? chanMask : '0;
            cfgLoad    <= doCmd && knownOp && opCode >= CMD_SILENCE_C;
            if (doCmd && knownOp) begin           // RULE_23
                cfgChannel <= opChan;
                cfgData    <= tempHold[0];
                cfgCommand <= opCode;
                if (opCode == CMD_OPTION_C)
                    optionReg <= tempHold[0];     // RULE_04
                if (opCode == CMD_DIRECT_C) begin
                    directCfg.rateCode <= tempHold[6][7:DIR_RATE_LSB];
                    directCfg.algo <= algo_e'(tempHold[6][3:DIR_ALGO_LSB]);
                end  // RULE_12 RULE_13 RULE_14
            end
        end
    end

    assign lpfEnable   = optionReg[OPT_LPF_BIT];      // RULE_04
    assign followerOut = optionReg[OPT_FOLLOWER_BIT]; // RULE_16

    // ========================================================
    // Sampling group selection
    // ========================================================
    group_e chanGroup [CHANNELS];
    genvar g;
    for (g = 0; g < CHANNELS; g++) begin : groupMap
        // Map rate code to its group
        assign chanGroup[g] =
            (chanRateCode[g] inside {4'h0, 4'h3, 4'h6, 4'h9}) ? GRP_ONE :
            (chanRateCode[g] inside {4'h1, 4'h4, 4'h7}) ? GRP_TWO :
            GRP_THREE;                                // RULE_02
    end

    // Lowest started channel among simultaneous starts
    logic [2:0] firstIdx;
    always_comb begin
        firstIdx = 3'h0;
        for (int i = CHANNELS - 1; i >= 0; i--)
            if (startPulse[i]) firstIdx = 3'(i);    // RULE_06
    end

    wire anyPlaying = |chanBusy;
    logic groupLocked;

    // First sounding channel fixes the group for the mix
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            activeGroup <= group_e'(GROUP_RESET);
            groupLocked <= 1'b0;
        end else if (!groupLocked && |startPulse
                     && chanRateValid[firstIdx]) begin
            activeGroup <= chanGroup[firstIdx];     // RULE_05 RULE_01
            groupLocked <= 1'b1;
        end else if (groupLocked && !anyPlaying && !(|startPulse)) begin
            groupLocked <= 1'b0;
        end
    end

    // ========================================================
    // Status and data bus
    // ========================================================
    logic [7:0] statusReg;
    wire        readSel = !csN && !rdN;
    logic       readPrev;
    wire [3:0]  nibble  = bankSel ? statusReg[7:4] : statusReg[3:0];

    // Status register and serial read shifter
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            statusReg <= 8'h00;
            readShift <= 8'h00;
            readPrev  <= 1'b0;
        end else begin
            statusReg <= chanBusy;                  // RULE_18
            readPrev  <= readSel;
            if (readSel && !readPrev)
                readShift <= statusReg;
            else if (readSel && sclkRise)
                readShift <= {readShift[6:0], 1'b0}; // RULE_19
        end
    end

    // Bus drive: parallel read or serial status pins
    always_comb begin
        hostDataOut = 8'h00;
        hostDataOe  = 8'h00;
        if (!rst_n) begin
            hostDataOe = 8'h00;
        end else if (!isSerial) begin
            hostDataOut = statusReg;                // RULE_21
            hostDataOe  = readSel ? 8'hFF : 8'h00;
        end else begin
            hostDataOut = {2'h0, readShift[7], 1'b0, nibble};
            hostDataOe  = 8'h2F;                    // RULE_20 RULE_19
        end
    end

    // ========================================================
    // Power-down and audio output
    // ========================================================
    // Step output held one sample period, grounded in reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            leftAudioOut  <= '0;                    // RULE_10
            rightAudioOut <= '0;
        end else if (sampleTick) begin
            leftAudioOut  <= leftSample;            // RULE_15
            rightAudioOut <= rightSample;
        end
    end

    assign oscEnable        = rst_n;                // RULE_07
    assign oscillatorPinOut = rst_n && xtal;        // RULE_08

    // ========================================================
    // Checks
    // ========================================================
    audio_ground_a: assert property (@(posedge clk_sys) // RULE_10
        !rst_n |=> leftAudioOut == '0 && rightAudioOut == '0)
        else $error("Audio not grounded in power-down");
    audio_hold_a: assert property (@(posedge clk_sys) // RULE_15
        disable iff (!rst_n) !sampleTick
        |=> $stable(leftAudioOut) && $stable(rightAudioOut))
        else $error("Audio changed between samples");
    osc_low_a: assert property (@(posedge clk_sys) // RULE_08
        !rst_n |-> !oscillatorPinOut && !oscEnable)
        else $error("Oscillator pin active in power-down");
    opt_load_a: assert property (@(posedge clk_sys) // RULE_04
        disable iff (!rst_n) doCmd && opCode == CMD_OPTION_C
        |=> lpfEnable == $past(tempHold[0][OPT_LPF_BIT]))
        else $error("Filter option not applied");
    start_mask_a: assert property (@(posedge clk_sys) // RULE_23
        disable iff (!rst_n) doCmd && opCode == CMD_START_C
        |=> startPulse == $past(chanMask))
        else $error("Start mask wrong");
    sub_nocmd_a: assert property (@(posedge clk_sys) // RULE_22
        disable iff (!rst_n) doSub |=> startPulse == '0 && !cfgLoad)
        else $error("Subcommand executed");
    par_read_a: assert property (@(posedge clk_sys) // RULE_21
        disable iff (!rst_n) !isSerial && readSel |-> hostDataOe == 8'hFF)
        else $error("Status not driven on read");
    ser_pins_a: assert property (@(posedge clk_sys) // RULE_20
        disable iff (!rst_n) isSerial
        |-> hostDataOe[7:6] == 2'h0 && !hostDataOe[4])
        else $error("Serial inputs driven");
    group_pick_a: assert property (@(posedge clk_sys) // RULE_06
        disable iff (!rst_n) !groupLocked && |startPulse
        && chanRateValid[firstIdx]
        |=> activeGroup == $past(chanGroup[firstIdx]))
        else $error("Wrong group adopted");
    cov_start_c: cover property (@(posedge clk_sys) |startPulse);
    cov_opt_c: cover property (@(posedge clk_sys) $rose(lpfEnable));
    cov_ser_c: cover property (@(posedge clk_sys) isSerial && sclkRise);
    cov_multi_c: cover property (@(posedge clk_sys)
        $countones(startPulse) > 1);

endmodule // voice_host_control

//--- tb/voice_host_model.sv
`timescale 1ns/1ps
// ========================================================
// Host controller model driving the control and bus pins
// ========================================================
module voice_host_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] busLevel,
    output logic            cmdSelect,
    output logic            chipSelect_n,
    output logic            write_n,
    output logic            read_n,
    output logic      [7:0] hostDrive
);
    // Idle: strobes high, serial clock parked low
    initial begin
        cmdSelect    = 1'b0;
        chipSelect_n = 1'b1;
        write_n      = 1'b1;
        read_n       = 1'b1;
        hostDrive    = 8'h00;
    end

    // Waits a number of clock edges
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Sends one byte, shifted when ser is high
    task automatic putByte(input logic sub, input logic [7:0] b,
                           input logic ser, input logic csN);
        @(posedge clk_sys);
        cmdSelect    <= sub;
        chipSelect_n <= csN;
        if (ser) begin
            for (int i = 7; i >= 0; i--) begin
                hostDrive[7] <= b[i];
                step(3);
                hostDrive[6] <= 1'b1;
                step(3);
                hostDrive[6] <= 1'b0;
            end
        end else begin
            hostDrive <= b;
        end
        step(3);
        write_n <= 1'b0;
        step(3);
        write_n <= 1'b1;
        step(3);
        chipSelect_n <= 1'b1;
        // Released data shows the inverse of the last value
        if (ser) hostDrive[7] <= ~b[0];
        else hostDrive <= ~b;
        step(3);
    endtask

    // Reads the bus while the read strobe is held low
    task automatic getByte(output logic [7:0] v);
        @(posedge clk_sys);
        chipSelect_n <= 1'b0;
        read_n       <= 1'b0;
        step(4);
        v = busLevel;
        read_n       <= 1'b1;
        chipSelect_n <= 1'b1;
        step(3);
    endtask

    // Reads status serially, MSB first, one bit per serial clock rise
    task automatic getSerial(output logic [7:0] v);
        @(posedge clk_sys);
        chipSelect_n <= 1'b0;
        read_n       <= 1'b0;
        step(4);
        for (int i = 7; i >= 0; i--) begin
            v[i] = busLevel[5];
            hostDrive[6] <= 1'b1;
            step(4);
            hostDrive[6] <= 1'b0;
            step(4);
        end
        read_n       <= 1'b1;
        chipSelect_n <= 1'b1;
        step(3);
    endtask
endmodule // voice_host_model

//--- tb/test_voice_host_control.sv
`timescale 1ns/1ps
module test_voice_host_control
    import voice_host_pkg::*;
;
    // ========================================================
    // Signals
    // ========================================================
    logic                 clk_sys, rst_n, serialSelect, crystalFitted;
    logic                 sampleTick, cmdSelect, chipSelect_n, write_n;
    logic                 read_n, oscEnable, oscillatorPinOut, cfgLoad;
    logic                 lpfEnable, followerOut;
    logic [7:0]           hostDrive, busLevel, hostDataOut, hostDataOe;
    logic [7:0]           chanBusy, chanRateValid, cfgData, rdVal;
    logic [3:0]           chanRateCode [CHANNELS];
    logic [DAC_WIDTH-1:0] leftSample, rightSample;
    logic [DAC_WIDTH-1:0] leftAudioOut, rightAudioOut;
    logic [CHANNELS-1:0]  startPulse, stopPulse, loopPulse;
    logic [2:0]           cfgChannel;
    logic [4:0]           cfgCommand;
    group_e               activeGroup;
    chan_cfg_s            directCfg;
    logic [23:0]          lastPulse = '0;
    logic [15:0]          lastCfg = '0;
    logic [1:0]           grpOf [10] = '{0, 1, 2, 0, 1, 2, 0, 1, 2, 0};
    int                   nPulse = 0, nCfg = 0, failures = 0, checks = 0;

    // Bus level from the controller's enables, host drive elsewhere
    assign busLevel = (hostDataOe & hostDataOut) | (~hostDataOe & hostDrive);

    voice_host_control voice_host_control_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .serialSelect(serialSelect),
        .cmdSelect(cmdSelect), .chipSelect_n(chipSelect_n),
        .write_n(write_n), .read_n(read_n), .hostDataIn(busLevel),
        .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
        .chanBusy(chanBusy), .chanRateValid(chanRateValid),
        .chanRateCode(chanRateCode), .crystalFitted(crystalFitted),
        .leftSample(leftSample), .rightSample(rightSample),
        .sampleTick(sampleTick), .oscEnable(oscEnable),
        .oscillatorPinOut(oscillatorPinOut), .leftAudioOut(leftAudioOut),
        .rightAudioOut(rightAudioOut), .lpfEnable(lpfEnable),
        .followerOut(followerOut), .activeGroup(activeGroup),
        .startPulse(startPulse), .stopPulse(stopPulse),
        .loopPulse(loopPulse), .cfgLoad(cfgLoad), .cfgChannel(cfgChannel),
        .cfgData(cfgData), .cfgCommand(cfgCommand), .directCfg(directCfg)
    );

    voice_host_model voice_host_model_i (
        .clk_sys(clk_sys), .busLevel(busLevel), .cmdSelect(cmdSelect),
        .chipSelect_n(chipSelect_n), .write_n(write_n), .read_n(read_n),
        .hostDrive(hostDrive)
    );

    // 50 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Counts pulse cycles and keeps the last values
    always @(posedge clk_sys) begin
        if (|{startPulse, stopPulse, loopPulse}) begin
            nPulse    <= nPulse + 1;
            lastPulse <= {startPulse, stopPulse, loopPulse};
        end
        if (cfgLoad) begin
            nCfg    <= nCfg + 1;
            lastCfg <= {cfgCommand, cfgChannel, cfgData};
        end
    end

    // ========================================================
    // Tasks
    // ========================================================
    task automatic check(input logic [27:0] got, input logic [27:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        if (failures == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Subcommand byte then command byte
    task automatic cmd(input logic [7:0] sub, input logic [7:0] op);
        voice_host_model_i.putByte(1'b1, sub, serialSelect, 1'b0);
        voice_host_model_i.putByte(1'b0, op, serialSelect, 1'b0);
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        stop_test();
    end

    // ========================================================
    // Test sequence
    // ========================================================
    initial begin
        int n;
        rst_n = 1'b0;
        serialSelect = 1'b0;
        crystalFitted = 1'b1;
        sampleTick = 1'b0;
        chanBusy = 8'h00;
        chanRateValid = 8'hFF;
        leftSample = '0;
        rightSample = '0;
        foreach (chanRateCode[i]) chanRateCode[i] = 4'h0;
        repeat (16) @(posedge clk_sys);
        check({leftAudioOut, rightAudioOut}, 28'h0);
        check({oscEnable, oscillatorPinOut, hostDataOe}, 28'h0);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check({oscEnable, oscillatorPinOut}, 28'h3);
        // Channel-mask commands: start, stop, loop
        for (int k = 0; k < 3; k++) begin
            n = nPulse;
            cmd(8'h81, {k[4:0], 3'h0});
            check(28'(nPulse - n), 28'h1);
            check(28'(lastPulse), 28'h81 << (16 - 8 * k));
        end
        // Group of each rate code, filter off
        for (int c = 0; c < 10; c++) begin
            chanRateCode[0] <= c[3:0];
            cmd(8'h01, 8'h00);
            check(28'(activeGroup), 28'(grpOf[c]));
        end
        // Started channels keep sounding, so the group stays locked
        chanRateCode[2] <= 4'h4;
        chanRateCode[3] <= 4'h2;
        chanRateCode[7] <= 4'h0;
        chanBusy <= 8'h8C;
        cmd(8'h8C, 8'h00);
        check(28'(activeGroup), 28'(GRP_TWO));
        cmd(8'h01, 8'h00);
        check(28'(activeGroup), 28'(GRP_TWO));
        cmd(8'h03, 8'h18);
        check({lpfEnable, followerOut}, 28'h3);
        // Filter on: a same-group channel joins the mix
        cmd(8'h04, 8'h00);
        check(28'(activeGroup), 28'(GRP_TWO));
        // Function commands with channel field
        for (int c = 4; c <= 8; c++) begin
            n = nCfg;
            cmd(8'h50 + 8'(c), {c[4:0], 3'h5});
            check(28'(nCfg - n), 28'h1);
            check(28'(lastCfg), {c[4:0], 3'h5, 8'h50 + 8'(c)});
        end
        // Seven-byte direct setup: rate and scheme in the last byte
        for (int b = 0; b < 6; b++)
            voice_host_model_i.putByte(1'b1, 8'(b), 1'b0, 1'b0);
        cmd(8'hA4, 8'h30);
        check(28'(directCfg), 28'h29);
        // Deselected write and unknown opcode are ignored
        n = nPulse + nCfg;
        voice_host_model_i.putByte(1'b0, 8'h00, 1'b0, 1'b1);
        cmd(8'hFF, 8'h48);
        check(28'(nPulse + nCfg - n), 28'h0);
        chanBusy <= 8'hA5;
        voice_host_model_i.getByte(rdVal);
        check(28'(rdVal), 28'hA5);
        check(28'(hostDataOe), 28'h0);
        // One sample step, held until the next tick
        leftSample <= 14'h1ABC;
        rightSample <= 14'h2345;
        sampleTick <= 1'b1;
        @(posedge clk_sys);
        sampleTick <= 1'b0;
        leftSample <= 14'h0111;
        repeat (3) @(posedge clk_sys);
        check({leftAudioOut, rightAudioOut}, {14'h1ABC, 14'h2345});
        // Serial interface, lower status bank selected first
        serialSelect <= 1'b1;
        voice_host_model_i.hostDrive[4] <= 1'b0;
        chanBusy <= 8'h3C;
        repeat (4) @(posedge clk_sys);
        check(28'(busLevel[3:0]), 28'hC);
        check(28'(hostDataOe), 28'h2F);
        voice_host_model_i.hostDrive[4] <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check(28'(busLevel[3:0]), 28'h3);
        cmd(8'h01, 8'h18);
        check({lpfEnable, followerOut}, 28'h2);
        voice_host_model_i.getSerial(rdVal);
        check(28'(rdVal), 28'h3C);
        // Reset in mid-run, external clock held low meanwhile
        rst_n <= 1'b0;
        crystalFitted <= 1'b0;
        repeat (3) @(posedge clk_sys);
        check({leftAudioOut, rightAudioOut}, 28'h0);
        check({oscillatorPinOut, lpfEnable, hostDataOe}, 28'h0);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check({oscEnable, oscillatorPinOut}, 28'h2);
        stop_test();
    end
endmodule // test_voice_host_control
